// ==== pkg/dsm_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface dsm_if;
   import dsm_pkg::*;
   dsm_word_t ctrl_word;
   dsm_word_t status_word;
   logic param_wr;
   logic [3:0] param_idx;
   dsm_word_t param_data;
   logic param_ack;
   logic param_err;
   modport dev (
      input ctrl_word, param_wr, param_idx, param_data,
      output status_word, param_ack, param_err
   );
   modport host (
      output ctrl_word, param_wr, param_idx, param_data,
      input status_word, param_ack, param_err
   );
endinterface : dsm_if
`default_nettype wire

// ==== pkg/dsm_pkg.sv ====
package dsm_pkg;
   typedef enum logic [3:0] {
      DSM_PWRON = 4'b0000,
      DSM_INIT = 4'b0001,
      DSM_DIS = 4'b0010,
      DSM_READY = 4'b0011,
      DSM_SWON = 4'b0100,
      DSM_OPEN = 4'b0101,
      DSM_QSTOP = 4'b0110,
      DSM_FSTOP = 4'b0111,
      DSM_FAULT = 4'b1000
   } dsm_state_t;
   typedef logic [15:0] dsm_word_t;
endpackage : dsm_pkg

// ==== pkg/dsm_regs.svh ====
`ifndef DSM_REGS_SVH
`define DSM_REGS_SVH

// control word: low nibble command codes, fault reset bit
`define DSM_CW_DISABLE 4'h0
`define DSM_CW_QSTOP 4'h2
`define DSM_CW_SHUTDOWN 4'h6
`define DSM_CW_SWITCH_ON 4'h7
`define DSM_CW_ENABLE 4'hf
`define DSM_CW_FRESET_BIT 7
`define DSM_CW_RESET 16'h0000

// status word values
`define DSM_SW_NONE 16'h0000
`define DSM_SW_DISABLED 16'h0070
`define DSM_SW_READY 16'h0031
`define DSM_SW_SWON 16'h0033
`define DSM_SW_OPEN 16'h0037
`define DSM_SW_QSTOP 16'h0050
`define DSM_SW_FSTOP 16'h003f
`define DSM_SW_FAULT 16'h0038

// quick-stop modes
`define DSM_QS_M0 8'h00
`define DSM_QS_M1 8'h01
`define DSM_QS_M2 8'h02
`define DSM_QS_M18 8'h12
`define DSM_QS_M5 8'h05
`define DSM_QS_M6 8'h06

// parameter store
`define DSM_PAR_AW 4
`define DSM_PAR_QSMODE 4'h0
`define DSM_PAR_LOCK_BASE 4'h8
`define DSM_PAR_RESET 16'h0000

// host APB register map
`define DSM_APB_AW 8
`define DSM_A_CTRL 8'h00
`define DSM_A_STATUS 8'h04
`define DSM_A_PARW 8'h08
`define DSM_A_PRES 8'h0c
`define DSM_PARW_IDX_LSB 16
`define DSM_PRES_BUSY 0
`define DSM_PRES_ACK 1
`define DSM_PRES_ERR 2

`endif

// ==== src/dsm_device.sv ====
// Contract
// - power-on passes to initialization by itself
// - initialization goes disabled once communication up
// - disabled plus control 6 gives ready, 31
// - ready plus control 7 gives running, 33
// - running plus F enables operation, 0037
// - operation enabled plus 7 gives running
// - running or enabled plus 6 gives ready
// - ready/running/enabled plus 0 gives disabled
// - enabled plus 2 starts quick stop, 0050
// - quick stop done, modes 0/1/2/18 disable
// - quick stop modes 5/6: F re-enables
// - fault in active states enters fault stop
// - fault stop passes to fault, power off
// - fault reset by 86 or pin, disabled
// - parameter writes rejected during initialization
// - ready state accepts parameter writes
// - operation enabled locks some parameters
// - no re-enable from fault without reset
// - control bits: on, voltage, quickstop_n, enable
// - status bits: ready, on, enabled, fault
// - fault reset acts on rising edge only
`timescale 1ns/10ps
`default_nettype none
`include "dsm_regs.svh"
module dsm_device import dsm_pkg::*; #(
   parameter int NPAR = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   dsm_if.dev link,
   input wire logic comm_up,
   input wire logic fault_in,
   input wire logic stop_done,
   input wire logic reset_pin,
   output logic main_power,
   output logic drive_enable,
   output logic quick_stop_active,
   output logic fault_stop_active,
   output logic [3:0] state_code
);
   dsm_state_t state;
   dsm_state_t next_state;
   dsm_word_t status;
   dsm_word_t par [NPAR];
   logic [3:0] cmd;
   logic fr_rise;
   logic pin_rise;
   logic [7:0] qs_mode;
   logic qs_disables;
   logic qs_resumes;
   logic fault_able;
   logic par_ok;
   logic fault_clear;

   function automatic logic is_cmd(input logic [3:0] c,
                                   input logic [3:0] code);
      is_cmd = (c == code);
   endfunction : is_cmd

   function automatic dsm_word_t status_of(input dsm_state_t ns,
                                           input dsm_state_t cs);
      dsm_word_t w;
      w = `DSM_SW_NONE;
      unique case (ns)
         DSM_DIS: w = (cs == DSM_FAULT) ? `DSM_SW_READY
                                        : `DSM_SW_DISABLED;
         DSM_READY: w = `DSM_SW_READY;
         DSM_SWON: w = `DSM_SW_SWON;
         DSM_OPEN: w = `DSM_SW_OPEN;
         DSM_QSTOP: w = `DSM_SW_QSTOP;
         DSM_FSTOP: w = `DSM_SW_FSTOP;
         DSM_FAULT: w = `DSM_SW_FAULT;
         default: w = `DSM_SW_NONE;
      endcase
      return w;
   endfunction : status_of

   // low nibble carries switch-on, voltage, quick stop (low), enable
   assign cmd = link.ctrl_word[3:0];

   dsm_edge u_freset (
      .pclk(pclk),
      .presetn(presetn),
      .din(link.ctrl_word[`DSM_CW_FRESET_BIT]),
      .rise(fr_rise)
   );

   dsm_edge u_pin (
      .pclk(pclk),
      .presetn(presetn),
      .din(reset_pin),
      .rise(pin_rise)
   );

   assign qs_mode = par[`DSM_PAR_QSMODE][7:0];
   assign qs_disables = (qs_mode == `DSM_QS_M0) ||
                        (qs_mode == `DSM_QS_M1) ||
                        (qs_mode == `DSM_QS_M2) ||
                        (qs_mode == `DSM_QS_M18);
   assign qs_resumes = (qs_mode == `DSM_QS_M5) ||
                       (qs_mode == `DSM_QS_M6);
   assign fault_able = (state == DSM_INIT) || (state == DSM_DIS) ||
                       (state == DSM_READY) || (state == DSM_SWON) ||
                       (state == DSM_OPEN) || (state == DSM_QSTOP);
   // a reset edge clears only while fault_in is low; an edge seen during the fault is lost
   assign fault_clear = (fr_rise || pin_rise) && !fault_in;

   always_comb begin
      next_state = state;
      unique case (state)
         DSM_PWRON: next_state = DSM_INIT;
         DSM_INIT: begin
            if (comm_up) next_state = DSM_DIS;
         end
         DSM_DIS: begin
            if (is_cmd(cmd, `DSM_CW_SHUTDOWN)) next_state = DSM_READY;
         end
         DSM_READY: begin
            if (is_cmd(cmd, `DSM_CW_SWITCH_ON)) begin
               next_state = DSM_SWON;
            end else if (is_cmd(cmd, `DSM_CW_DISABLE)) begin
               next_state = DSM_DIS;
            end
         end
         DSM_SWON: begin
            if (is_cmd(cmd, `DSM_CW_ENABLE)) begin
               next_state = DSM_OPEN;
            end else if (is_cmd(cmd, `DSM_CW_SHUTDOWN)) begin
               next_state = DSM_READY;
            end else if (is_cmd(cmd, `DSM_CW_DISABLE)) begin
               next_state = DSM_DIS;
            end
         end
         DSM_OPEN: begin
            if (is_cmd(cmd, `DSM_CW_SWITCH_ON)) begin
               next_state = DSM_SWON;
            end else if (is_cmd(cmd, `DSM_CW_SHUTDOWN)) begin
               next_state = DSM_READY;
            end else if (is_cmd(cmd, `DSM_CW_DISABLE)) begin
               next_state = DSM_DIS;
            end else if (is_cmd(cmd, `DSM_CW_QSTOP)) begin
               next_state = DSM_QSTOP;
            end
         end
         DSM_QSTOP: begin
            if (stop_done && qs_disables) begin
               next_state = DSM_DIS;
            end else if (qs_resumes && is_cmd(cmd, `DSM_CW_ENABLE)) begin
               next_state = DSM_OPEN;
            end
         end
         DSM_FSTOP: begin
            if (stop_done) next_state = DSM_FAULT;
         end
         DSM_FAULT: begin
            if (fault_clear) next_state = DSM_DIS;
         end
         default: next_state = DSM_PWRON;
      endcase
      // a fault outranks any command in the same cycle
      if (fault_in && fault_able) next_state = DSM_FSTOP;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= DSM_PWRON;
         status <= `DSM_SW_NONE;
      end else begin
         state <= next_state;
         if (next_state != state) begin
            status <= status_of(next_state, state);
         end
      end
   end
   assign link.status_word = status;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_power <= 1'b0;
         drive_enable <= 1'b0;
         quick_stop_active <= 1'b0;
         fault_stop_active <= 1'b0;
         state_code <= DSM_PWRON;
      end else begin
         // power stays on while a stop ramp runs; off in fault
         main_power <= (next_state == DSM_OPEN) ||
                       (next_state == DSM_QSTOP) ||
                       (next_state == DSM_FSTOP);
         drive_enable <= (next_state == DSM_OPEN);
         quick_stop_active <= (next_state == DSM_QSTOP);
         fault_stop_active <= (next_state == DSM_FSTOP);
         state_code <= next_state;
      end
   end

   // parameter writes: none in power-on or init, locked ones when enabled
   assign par_ok = (int'(link.param_idx) < NPAR) &&
                   (state != DSM_PWRON) && (state != DSM_INIT) &&
                   !((state == DSM_OPEN) &&
                     (link.param_idx >= `DSM_PAR_LOCK_BASE));

   for (genvar i = 0; i < NPAR; i++) begin : g_par
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            par[i] <= `DSM_PAR_RESET;
         end else if (link.param_wr && par_ok &&
                      (int'(link.param_idx) == i)) begin
            par[i] <= link.param_data;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.param_ack <= 1'b0;
         link.param_err <= 1'b0;
      end else begin
         link.param_ack <= link.param_wr && par_ok;
         link.param_err <= link.param_wr && !par_ok;
      end
   end
endmodule : dsm_device
`default_nettype wire

// ==== src/dsm_edge.sv ====
`timescale 1ns/10ps
`default_nettype none
module dsm_edge (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic din,
   output logic rise
);
   logic prev;
   // reset high so a level already held at reset is no edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prev <= 1'b1;
      else prev <= din;
   end
   assign rise = din & ~prev;
endmodule : dsm_edge
`default_nettype wire

// ==== src/dsm_host.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dsm_regs.svh"
module dsm_host import dsm_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   dsm_if.host link
);
   dsm_word_t ctrl;
   logic busy;
   logic ack;
   logic err;
   logic setup;
   logic commit;
   logic hit_ctrl;
   logic hit_status;
   logic hit_parw;
   logic hit_pres;
   logic mapped;
   logic bad;
   logic launch;
   logic [31:0] rd_mux;

   assign setup = psel && !penable;
   assign commit = psel && penable && pready;
   assign hit_ctrl = (paddr == `DSM_A_CTRL);
   assign hit_status = (paddr == `DSM_A_STATUS);
   assign hit_parw = (paddr == `DSM_A_PARW);
   assign hit_pres = (paddr == `DSM_A_PRES);
   assign mapped = hit_ctrl || hit_status || hit_parw || hit_pres;
   // status is read-only; a second parameter write while one is
   // in flight is refused rather than queued
   assign bad = !mapped || (pwrite && hit_status) ||
                (pwrite && hit_parw && busy);
   assign launch = commit && pwrite && hit_parw && !pslverr;
   assign rd_mux = hit_ctrl ? {16'h0000, ctrl} :
                   hit_status ? {16'h0000, link.status_word} :
                   hit_pres ? {29'h0000000, err, ack, busy} :
                   32'h00000000;

   // one wait-free access cycle: pready rises in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= setup;
         pslverr <= setup && bad;
         prdata <= (setup && !pwrite && !bad) ? rd_mux : 32'h00000000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `DSM_CW_RESET;
      end else if (commit && pwrite && hit_ctrl) begin
         ctrl <= pwdata[15:0];
      end
   end
   assign link.ctrl_word = ctrl;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link.param_wr <= 1'b0;
         link.param_idx <= 4'h0;
         link.param_data <= 16'h0000;
      end else begin
         link.param_wr <= launch;
         if (launch) begin
            link.param_idx <= pwdata[`DSM_PARW_IDX_LSB +: `DSM_PAR_AW];
            link.param_data <= pwdata[15:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy <= 1'b0;
         ack <= 1'b0;
         err <= 1'b0;
      end else if (launch) begin
         busy <= 1'b1;
         ack <= 1'b0;
         err <= 1'b0;
      end else if (link.param_ack || link.param_err) begin
         busy <= 1'b0;
         ack <= link.param_ack;
         err <= link.param_err;
      end
   end
endmodule : dsm_host
`default_nettype wire

// ==== testbench/dsm_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module dsm_asserts import dsm_pkg::*; (
   input wire logic pclk,
   input wire logic presetn,
   input wire dsm_word_t ctrl_word,
   input wire dsm_word_t status_word,
   input wire logic param_wr,
   input wire logic param_ack,
   input wire logic param_err
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire [3:0] nib = ctrl_word[3:0];
   wire [15:0] sw = status_word;
   wire on_or_en = sw == 16'h0033 || sw == 16'h0037;
   sequence fstop_exit;
      sw == 16'h003f ##1 sw != 16'h003f;
   endsequence
   sequence fault_exit;
      sw == 16'h0038 ##1 sw != 16'h0038;
   endsequence
   AST_DIS_READY: assert property (
      sw == 16'h0070 && nib == 4'h6 |=> sw == 16'h0031)
      else $error("ready not reached");
   AST_SWON_OPEN: assert property (
      sw == 16'h0033 && nib == 4'hf |=> sw == 16'h0037)
      else $error("operation not enabled");
   AST_OPEN_SWON: assert property (
      sw == 16'h0037 && nib == 4'h7 |=> sw == 16'h0033)
      else $error("no fall back to running");
   AST_BACK_READY: assert property (
      on_or_en && nib == 4'h6 |=> sw == 16'h0031)
      else $error("no return to ready");
   AST_TO_DIS: assert property (
      on_or_en && nib == 4'h0 |=> sw == 16'h0070)
      else $error("no return to disabled");
   AST_QSTOP: assert property (
      sw == 16'h0037 && nib == 4'h2 |=> sw == 16'h0050)
      else $error("quick stop not entered");
   AST_UNMATCHED: assert property (
      sw == 16'h0070 && (nib == 4'h2 || nib == 4'h7 || nib == 4'hf)
      |=> $stable(sw)) else $error("illegal code changed status");
   AST_FAULT_OUT: assert property (
      fstop_exit |-> sw == 16'h0038) else $error("fault stop exit wrong");
   AST_FAULT_CLEAR: assert property (
      fault_exit |-> sw == 16'h0031) else $error("fault left wrongly");
   AST_PAR_ANSWER: assert property (
      param_wr |=> param_ack != param_err)
      else $error("parameter write unanswered");
endmodule : dsm_asserts
`default_nettype wire

// ==== testbench/test_drive_state_machine.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "dsm_regs.svh"
module test_drive_state_machine import dsm_pkg::*; ();
   logic pclk, presetn, psel, penable, pwrite, se, pready, pslverr;
   logic [7:0] paddr, qm;
   logic [31:0] pwdata, prdata, rd;
   logic comm_up, fault_in, stop_done, reset_pin, main_power, drive_en;
   logic qs_act, fs_act;
   logic [3:0] state_code;
   int err_total, checks, seed;
   dsm_state_t st;
   logic [3:0] walk [24] = '{7, 15, 6, 7, 15, 7, 15, 6, 7, 0, 6, 0, 6, 7,
      15, 6, 7, 15, 0, 6, 7, 6, 2, 0};
   logic [3:0] cmds [5] = '{0, 2, 6, 7, 15};
   logic [7:0] qms [6] = '{0, 1, 2, 8'h12, 5, 6};
   dsm_if bus();
   dsm_host dsm_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(bus));
   dsm_device dsm_device_i (.pclk(pclk), .presetn(presetn), .link(bus),
      .comm_up(comm_up), .fault_in(fault_in), .stop_done(stop_done),
      .reset_pin(reset_pin), .main_power(main_power),
      .drive_enable(drive_en), .quick_stop_active(qs_act),
      .fault_stop_active(fs_act), .state_code(state_code));
   dsm_asserts dsm_asserts_i (.pclk(pclk), .presetn(presetn),
      .ctrl_word(bus.ctrl_word), .status_word(bus.status_word),
      .param_wr(bus.param_wr), .param_ack(bus.param_ack),
      .param_err(bus.param_err));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   task automatic chk(string what, logic [31:0] got, logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude
   // called just after a rising edge; the request stands until pready is
   // seen high at an edge, data is taken there, then one idle edge passes
   // so a following read sees the state that the write caused
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      se = pslverr;
      chk("pready", 32'(pready), 1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   function automatic dsm_state_t nxt(dsm_state_t s, logic [3:0] n);
      case (s)
         DSM_DIS: return n == 4'h6 ? DSM_READY : s;
         DSM_READY: return n == 4'h7 ? DSM_SWON : n == 4'h0 ? DSM_DIS : s;
         DSM_SWON: return n == 4'hf ? DSM_OPEN : n == 4'h6 ? DSM_READY :
            n == 4'h0 ? DSM_DIS : s;
         DSM_OPEN: return n == 4'h7 ? DSM_SWON : n == 4'h6 ? DSM_READY :
            n == 4'h0 ? DSM_DIS : n == 4'h2 ? DSM_QSTOP : s;
         DSM_QSTOP: return (n == 4'hf && (qm == 5 || qm == 6)) ? DSM_OPEN : s;
         default: return s;
      endcase
   endfunction : nxt
   function automatic logic [15:0] swof(dsm_state_t s);
      case (s)
         DSM_DIS: return 16'h0070;
         DSM_READY: return 16'h0031;
         DSM_SWON: return 16'h0033;
         DSM_OPEN: return 16'h0037;
         DSM_QSTOP: return 16'h0050;
         default: return 16'h0000;
      endcase
   endfunction : swof
   task automatic rdst(logic [15:0] x);
      apb(1'b0, `DSM_A_STATUS, 32'h0);
      chk("status", rd, {16'h0, x});
   endtask : rdst
   task automatic step(logic [3:0] n);
      apb(1'b1, `DSM_A_CTRL, {28'h0, n});
      st = nxt(st, n);
      rdst(swof(st));
      chk("state", 32'(state_code), 32'(st));
      chk("power", {29'h0, qs_act, main_power, drive_en}, {29'h0,
         st == DSM_QSTOP, st == DSM_OPEN || st == DSM_QSTOP,
         st == DSM_OPEN});
   endtask : step
   task automatic par(logic [3:0] idx, logic [15:0] d, logic bad);
      int n;
      n = 0;
      apb(1'b1, `DSM_A_PARW, {12'h0, idx, d});
      do begin
         apb(1'b0, `DSM_A_PRES, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 10);
      chk("param", rd, bad ? 32'h4 : 32'h2);
   endtask : par
   initial begin
      #5_000_000;
      err_total++;
      conclude();
   end
   initial begin
      seed = 42819;
      {psel, penable, pwrite, paddr, pwdata, qm} = '0;
      {comm_up, fault_in, stop_done, reset_pin, presetn} = '0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("init", 32'(state_code), 1);
      par(4'h0, 16'h0, 1'b1);
      comm_up <= 1'b1;
      repeat (3) @(posedge pclk);
      st = DSM_DIS;
      chk("dis", 32'(state_code), 2);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", 32'(se), 1);
      apb(1'b1, `DSM_A_STATUS, 32'h1);
      chk("read only", 32'(se), 1);
      $display("test reset done");
      foreach (walk[k])
         step(walk[k]);
      step(6);
      par(4'h9, 16'h1, 1'b0);
      step(7);
      step(15);
      par(4'h9, 16'h1, 1'b1);
      par(4'h3, 16'h1, 1'b0);
      step(0);
      $display("test walk done");
      foreach (qms[k]) begin
         qm = qms[k];
         par(4'h0, {8'h0, qm}, 1'b0);
         step(6);
         step(7);
         step(15);
         step(2);
         if (qm == 5 || qm == 6)
            step(15);
         else begin
            stop_done <= 1'b1;
            @(posedge pclk);
            stop_done <= 1'b0;
            st = DSM_DIS;
            step(2);
         end
         step(0);
      end
      $display("test quick stop done");
      for (int k = 0; k < 2; k++) begin
         if (k == 0) begin
            step(6);
            step(7);
            step(15);
         end
         fault_in <= 1'b1;
         repeat (2) @(posedge pclk);
         chk("fault stop", 32'(fs_act), 1);
         stop_done <= 1'b1;
         @(posedge pclk);
         stop_done <= 1'b0;
         apb(1'b1, `DSM_A_CTRL, 32'h8f);
         rdst(16'h0038);
         chk("fault power", 32'(main_power), 0);
         fault_in <= 1'b0;
         if (k == 0) begin
            apb(1'b1, `DSM_A_CTRL, 32'hf);
            rdst(16'h0038);
            apb(1'b1, `DSM_A_CTRL, 32'h86);
            st = DSM_READY;
         end else begin
            reset_pin <= 1'b1;
            @(posedge pclk);
            reset_pin <= 1'b0;
            st = DSM_DIS;
         end
         rdst(16'h0031);
         // disabled entered from fault keeps 0031, so leave it by 6
         step(k == 0 ? 4'h0 : 4'h6);
      end
      $display("test fault done");
      for (int k = 0; k < 40; k++)
         step(cmds[$unsigned($random(seed)) % 5]);
      $display("test random done");
      presetn <= 1'b0;
      @(posedge pclk);
      chk("reset", 32'(state_code), 0);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      chk("restart", 32'(state_code), 2);
      $display("test second reset done");
      conclude();
   end
endmodule : test_drive_state_machine
`default_nettype wire
